// file: core/two_level_interrupt_dispatch.sv
// interrupt dispatcher: sampling, two-level priority, vectored call and enable register
`timescale 1ns/1ns
`default_nettype none
`include "irq_dispatch_map.svh"

// Functional notes
// - sample and resolve requests every clock
// - best case: detect one, call five clocks
// - after return, one instruction before call
// - worst case twenty clocks, no competing service
// - equal or lower priority waits for return
// - core stall defers the dispatch
// - vectors from 0x0003, eight bytes apart
// - clear external and timer0/1 flags on call
// - enable register: global bit 7, seven locals
// - high preempts low, high never preempted
// - flag still set after return re-requests
module two_level_interrupt_dispatch
    import irq_dispatch_pkg::*;
#(
    parameter int SRC_N = `IRQ_SRC_COUNT,
    parameter int IDX_W = `IRQ_IDX_W
) (
    input  wire logic                                clk,
    input  wire logic                                rstn,
    input  wire logic [SRC_N-1:0]                    pendingIn,
    input  wire logic [SRC_N-1:0]                    srcPriorityHigh,
    input  wire logic [SRC_N-1:`IRQ_LOCAL_EN_W]      extraEnable,
    input  wire logic                                instrDone,
    input  wire logic                                retiDone,
    input  wire logic                                coreStall,
    input  wire logic [7:0]                          sfrAddr,
    input  wire logic                                sfrWrite,
    input  wire logic [7:0]                          sfrWrData,
    output logic [7:0]                               sfrRdData,
    output logic [SRC_N-1:0]                         hwClearPending,
    output logic                                     callStart,
    output logic                                     callActive,
    output irq_dispatch_pkg::code_addr_t             callVector,
    output irq_dispatch_pkg::src_idx_t               callSource,
    output logic                                     highInService,
    output logic                                     lowInService
);
    import irq_dispatch_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable register
    logic [7:0] enableReg;
    logic [7:0] next_enableReg;
    logic [7:0] next_sfrRdData;

    always_comb begin
        next_enableReg = enableReg;
        if (sfrWrite && sfrAddr == `IRQ_ENABLE_ADDR) begin
            next_enableReg = sfrWrData;
        end
        next_sfrRdData = (sfrAddr == `IRQ_ENABLE_ADDR) ? enableReg : 8'h00;
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            enableReg <= `IRQ_ENABLE_RESET;
            sfrRdData <= 8'h00;
        end else begin
            enableReg <= next_enableReg;
            sfrRdData <= next_sfrRdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request sampling and priority decode
    logic [SRC_N-1:0] localEnable;
    logic [SRC_N-1:0] effReq;
    logic [SRC_N-1:0] highReq;
    logic [SRC_N-1:0] lowReq;
    logic [SRC_N-1:0] candReq;
    logic             highAllowed;
    logic             lowAllowed;
    logic             pickFound;
    logic [IDX_W-1:0] pickIdx;

    assign localEnable = {extraEnable, enableReg[`IRQ_LOCAL_EN_W-1:0]};
    // global bit off overrides every local mask
    assign effReq      = enableReg[`IRQ_GLOBAL_BIT] ? (pendingIn & localEnable) : '0;
    assign highReq     = effReq & srcPriorityHigh;
    assign lowReq      = effReq & ~srcPriorityHigh;
    assign highAllowed = !highInService;
    assign lowAllowed  = !highInService && !lowInService;
    always_comb begin
        candReq = '0;
        if (highAllowed && |highReq) begin
            candReq = highReq;
        end else if (lowAllowed) begin
            candReq = lowReq;
        end
    end

    irq_priority_pick #(
        .N (SRC_N),
        .W (IDX_W)
    ) i_irq_priority_pick (
        .req   (candReq),
        .found (pickFound),
        .idx   (pickIdx)
    );

    // detection stage: one registered clock, refreshed every cycle
    logic             reqValid;
    logic [IDX_W-1:0] reqIdx;
    logic             reqHigh;

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            reqValid <= 1'b0;
            reqIdx   <= '0;
            reqHigh  <= 1'b0;
        end else begin
            reqValid <= pickFound;
            reqIdx   <= pickIdx;
            reqHigh  <= |(highReq & candReq);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // vectored call sequencing and in-service levels
    dispatch_state_e                 state;
    dispatch_state_e                 next_state;
    logic [`IRQ_CALL_CNT_W-1:0]      callCnt;
    logic [`IRQ_CALL_CNT_W-1:0]      next_callCnt;
    logic                            next_high;
    logic                            next_low;
    code_addr_t                      next_vector;
    src_idx_t                        next_source;
    logic [SRC_N-1:0]                next_clear;
    logic                            takeReq;

    // a request stays up to the instruction boundary; stalls hold it off
    // the return's own boundary never calls, so at least one more instruction runs
    assign takeReq   = state == DISPATCH_IDLE && reqValid && instrDone && !coreStall
                       && !retiDone;
    assign callStart = takeReq;
    assign callActive = state == DISPATCH_CALL;

    always_comb begin
        next_state   = state;
        next_callCnt = callCnt;
        next_high    = highInService;
        next_low     = lowInService;
        next_vector  = callVector;
        next_source  = callSource;
        next_clear   = '0;
        // return pops the level; a still-set flag re-requests on the next sample
        if (retiDone) begin
            if (highInService) begin
                next_high = 1'b0;
            end else begin
                next_low = 1'b0;
            end
        end
        case (state)
            DISPATCH_IDLE: begin
                if (takeReq) begin
                    next_state   = DISPATCH_CALL;
                    next_callCnt = '0;
                    next_vector  = `IRQ_VECTOR_BASE
                                   + (16'(reqIdx) << `IRQ_VECTOR_SHIFT);
                    next_source  = reqIdx;
                    next_clear   = `IRQ_HW_CLEAR_MASK & (SRC_N'(1) << reqIdx);
                    if (reqHigh) begin
                        next_high = 1'b1;
                    end else begin
                        next_low = 1'b1;
                    end
                end
            end
            DISPATCH_CALL: begin
                if (callCnt == `IRQ_CALL_CYCLES - 1) begin
                    next_state = DISPATCH_IDLE;
                end else begin
                    next_callCnt = callCnt + 1'b1;
                end
            end
            default: begin
                next_state = DISPATCH_IDLE;
            end
        endcase
    end

    assign hwClearPending = next_clear;

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            state         <= DISPATCH_IDLE;
            callCnt       <= '0;
            highInService <= 1'b0;
            lowInService  <= 1'b0;
            callVector    <= `IRQ_RESET_VECTOR;
            callSource    <= '0;
        end else begin
            state         <= next_state;
            callCnt       <= next_callCnt;
            highInService <= next_high;
            lowInService  <= next_low;
            callVector    <= next_vector;
            callSource    <= next_source;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    call_length_a: assert property (@(posedge clk) disable iff (!rstSync)
        callStart |=> callActive [*5] ##1 !callActive)
        else $error("vectored call did not last five clocks");

    stall_defer_a: assert property (@(posedge clk) disable iff (!rstSync)
        coreStall |-> !callStart)
        else $error("call started during core stall");

    hw_clear_a: assert property (@(posedge clk) disable iff (!rstSync)
        callStart |-> hwClearPending == (17'h0000F & (17'h1 << reqIdx)))
        else $error("wrong hardware flag clear on call");

    global_off_a: assert property (@(posedge clk) disable iff (!rstSync)
        !enableReg[7] |=> !reqValid)
        else $error("request seen with global enable off");

    high_nopreempt_a: assert property (@(posedge clk) disable iff (!rstSync)
        highInService && !retiDone |-> !callStart)
        else $error("high-level service preempted");

    equal_wait_a: assert property (@(posedge clk) disable iff (!rstSync)
        lowInService && callStart |-> reqHigh)
        else $error("equal level request preempted low service");

    return_from_service_hold_a: assert property (@(posedge clk) disable iff (!rstSync)
        retiDone |-> !callStart)
        else $error("call made without one instruction after return");

    vector_value_a: assert property (@(posedge clk) disable iff (!rstSync)
        callStart |=> callVector == 16'h0003 + {$past(reqIdx), 3'b000})
        else $error("vector address mismatch");

    resample_a: assert property (@(posedge clk) disable iff (!rstSync)
        |candReq |=> reqValid && reqIdx == $past(pickIdx))
        else $error("request not sampled next clock");

    tie_order_a: assert property (@(posedge clk) disable iff (!rstSync)
        |candReq |-> (candReq & ((17'h1 << pickIdx) - 17'h1)) == 17'h0)
        else $error("tie not won by lowest order");

    best_case_c: cover property (@(posedge clk) disable iff (!rstSync)
        !reqValid ##1 callStart);
    preempt_c: cover property (@(posedge clk) disable iff (!rstSync)
        lowInService && callStart);
    return_from_service_again_c: cover property (@(posedge clk) disable iff (!rstSync)
        retiDone ##[1:10] callStart);
endmodule // two_level_interrupt_dispatch
`default_nettype wire

// file: core/irq_dispatch_map.svh
// constants for the two-level interrupt dispatcher
`ifndef IRQ_DISPATCH_MAP_SVH
`define IRQ_DISPATCH_MAP_SVH

`define IRQ_SRC_COUNT       17
`define IRQ_IDX_W           5
`define IRQ_ENABLE_ADDR     8'hA8
`define IRQ_ENABLE_RESET    8'h00
`define IRQ_GLOBAL_BIT      7
`define IRQ_LOCAL_EN_W      7
`define IRQ_RESET_VECTOR    16'h0000
`define IRQ_VECTOR_BASE     16'h0003
`define IRQ_VECTOR_SHIFT    3
`define IRQ_HW_CLEAR_MASK   17'h0000F
`define IRQ_DETECT_CYCLES   1
`define IRQ_CALL_CYCLES     5
`define IRQ_CALL_CNT_W      3

`endif

// file: core/irq_dispatch_pkg.sv
// types for the two-level interrupt dispatcher
package irq_dispatch_pkg;
    typedef enum logic [1:0] {
        DISPATCH_IDLE,
        DISPATCH_CALL
    } dispatch_state_e;

    typedef logic [4:0] src_idx_t;
    typedef logic [15:0] code_addr_t;
endpackage : irq_dispatch_pkg

// file: core/irq_priority_pick.sv
// fixed-order pick of the lowest-numbered active request
`timescale 1ns/1ns
`default_nettype none
module irq_priority_pick #(
    parameter int N = 17,
    parameter int W = 5
) (
    input  wire logic [N-1:0] req,
    output logic              found,
    output logic [W-1:0]      idx
);
    logic [N:0] below;

    assign below[0] = 1'b0;
    assign found    = below[N];

    // chain of "some lower source already wins"
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_chain
            assign below[i+1] = below[i] | req[i];
        end
    endgenerate

    always_comb begin
        idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (req[k]) begin
                idx = W'(k);
            end
        end
    end
endmodule // irq_priority_pick
`default_nettype wire

// file: tb/core_seq_model.sv
// behavioural core sequencer: instruction boundaries, returns and stalls
`timescale 1ns/1ns
`default_nettype none
module core_seq_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] instrLen,
    input  wire logic       retReq,
    input  wire logic       stallReq,
    input  wire logic       callBusy,
    output logic            instrDone,
    output logic            retiDone,
    output logic            coreStall
);
    logic [3:0] cnt;
    logic       retPend;
    ////////////////////////////////////////////////////////////////////////////
    assign coreStall = stallReq;
    // no boundary while stalled or while the call sequence owns the core
    assign instrDone = (cnt >= instrLen - 4'h1) && !coreStall && !callBusy;
    assign retiDone  = instrDone && retPend;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt     <= 4'h0;
            retPend <= 1'b0;
        end else begin
            cnt     <= instrDone ? 4'h0 : ((coreStall || callBusy) ? cnt : cnt + 4'h1);
            retPend <= retiDone ? 1'b0 : (retPend | retReq);
        end
    end
endmodule // core_seq_model
`default_nettype wire

// file: tb/two_level_interrupt_dispatch_test.sv
// self-checking bench for the interrupt dispatcher
`timescale 1ns/1ns
`default_nettype none
module two_level_interrupt_dispatch_test;
    import irq_dispatch_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, sfrWrite = 1'b0, retReq = 1'b0, stallReq = 1'b0;
    logic [16:0] pendingIn = '0, prioHigh = '0, hwClear;
    logic [16:7] extraEnable = '0;
    logic [7:0]  sfrAddr = '0, sfrWrData = '0, sfrRdData;
    logic [3:0]  instrLen = 4'h1;
    src_idx_t    callSource;
    code_addr_t  callVector;
    logic        callStart, callActive, highSvc, lowSvc, instrDone, retiDone, coreStall;
    int          errCount = 0, nChecks = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    two_level_interrupt_dispatch i_two_level_interrupt_dispatch (.clk(clk), .rstn(rstn),
        .pendingIn(pendingIn), .srcPriorityHigh(prioHigh), .extraEnable(extraEnable),
        .instrDone(instrDone), .retiDone(retiDone), .coreStall(coreStall), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
        .hwClearPending(hwClear), .callStart(callStart), .callActive(callActive),
        .callVector(callVector), .callSource(callSource), .highInService(highSvc),
        .lowInService(lowSvc));
    core_seq_model i_core_seq_model (.clk(clk), .rstn(rstn), .instrLen(instrLen),
        .retReq(retReq), .stallReq(stallReq), .callBusy(callActive), .instrDone(instrDone),
        .retiDone(retiDone), .coreStall(coreStall));
    initial begin
        forever #10 clk = ~clk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            tallyAndFinish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tallyAndFinish();
        $display("checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrite <= 1'b1;
        @(posedge clk);
        sfrWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfrAddr <= a;
        @(posedge clk);
        @(negedge clk);
        v = sfrRdData;
    endtask
    task automatic waitCall(input int maxN, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (callStart !== 1'b1 && n < maxN);
        if (callStart !== 1'b1) n = 0;
    endtask
    // software-cleared flags are dropped here too, the bench acting as the routine
    task automatic expectCall(input int maxN, input logic [4:0] src, output int n);
        waitCall(maxN, n);
        check(17'(n != 0), 17'h1);
        check(hwClear, (17'h1 << src) & 17'h0000F);
        @(posedge clk);
        pendingIn[src] <= 1'b0;
        @(negedge clk);
        check(17'(callVector), 17'h3 + (17'(src) << 3));
        check(17'(callSource), 17'(src));
    endtask
    task automatic retIsr();
        @(posedge clk);
        retReq <= 1'b1;
        @(posedge clk);
        retReq <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // counts boundaries after the return up to and including the one that calls
    task automatic retCount(output int k);
        bit seen;
        seen = 0;
        k = 0;
        @(posedge clk);
        retReq <= 1'b1;
        @(posedge clk);
        retReq <= 1'b0;
        for (int i = 0; i < 40 && callStart !== 1'b1; i++) begin
            @(negedge clk);
            if (seen && instrDone === 1'b1) k++;
            if (retiDone === 1'b1) seen = 1;
        end
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic scnRegs();
        logic [7:0] v;
        int         n;
        rd(8'hA8, v);
        check(17'(v), 17'h00);
        wr(8'hA8, 8'h5A);
        wr(8'hA9, 8'hFF);
        rd(8'hA9, v);
        check(17'(v), 17'h00);
        rd(8'hA8, v);
        check(17'(v), 17'h5A);
        wr(8'hA8, 8'h7F);
        extraEnable <= '1;
        pendingIn[9] <= 1'b1;
        waitCall(10, n);
        check(17'(n), 17'h0);
        wr(8'hA8, 8'h80);
        expectCall(4, 5'd9, n);
        retIsr();
    endtask
    task automatic scnVectors();
        int n;
        int k;
        for (int s = 0; s < 17; s++) begin
            wr(8'hA8, (s < 7) ? 8'(8'h80 | (1 << s)) : 8'h80);
            extraEnable <= (s >= 7) ? 10'(1 << (s - 7)) : 10'h0;
            pendingIn[s] <= 1'b1;
            expectCall(2, 5'(s), n);
            check(17'(n), 17'd2);
            check(17'(lowSvc), 17'h1);
            k = 0;
            while (callActive === 1'b1 && k < 9) begin
                k++;
                @(negedge clk);
            end
            check(17'(k), 17'd5);
            retIsr();
        end
    endtask
    task automatic scnStall();
        int n;
        wr(8'hA8, 8'h82);
        stallReq <= 1'b1;
        pendingIn[1] <= 1'b1;
        waitCall(10, n);
        check(17'(n), 17'h0);
        @(posedge clk);
        stallReq <= 1'b0;
        expectCall(3, 5'd1, n);
        retIsr();
    endtask
    task automatic scnReturn();
        int n;
        wr(8'hA8, 8'h94);
        pendingIn <= 17'h14;
        expectCall(3, 5'd2, n);
        waitCall(10, n);
        check(17'(n), 17'h0);
        instrLen <= 4'h3;
        retCount(n);
        check(17'(n), 17'd1);
        check(17'(callSource), 17'd4);
        retCount(n);
        check(17'(n), 17'd1);
        pendingIn <= '0;
        instrLen <= 4'h1;
        retIsr();
    endtask
    task automatic scnPreempt();
        int n;
        prioHigh <= 17'h00001;
        wr(8'hA8, 8'h87);
        pendingIn[2] <= 1'b1;
        expectCall(3, 5'd2, n);
        pendingIn[1] <= 1'b1;
        waitCall(10, n);
        check(17'(n), 17'h0);
        pendingIn[0] <= 1'b1;
        expectCall(3, 5'd0, n);
        check(17'(highSvc), 17'h1);
        prioHigh[1] <= 1'b1;
        waitCall(10, n);
        check(17'(n), 17'h0);
        pendingIn <= '0;
        retIsr();
        retIsr();
        check(17'({highSvc, lowSvc}), 17'h0);
        prioHigh <= '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        scnRegs();
        scnVectors();
        scnStall();
        scnReturn();
        scnPreempt();
        tallyAndFinish();
    end
endmodule // two_level_interrupt_dispatch_test
`default_nettype wire
